/* File: link_adaptor_map.svh */
`ifndef LINK_ADAPTOR_MAP_SVH
`define LINK_ADAPTOR_MAP_SVH

// register select codes on the two select lines
`define LA_SEL_DATA 2'h0
`define LA_SEL_TXDATA 2'h1
`define LA_SEL_RXSTAT 2'h2
`define LA_SEL_TXSTAT 2'h3

// status register field positions
`define LA_FLAG_BIT 0
`define LA_IE_BIT 1

// reset values
`define LA_RX_FULL_RST 1'b0
`define LA_TX_EMPTY_RST 1'b1
`define LA_IE_RST 1'b0
`define LA_BYTE_RST 8'h00

// receive buffer shape
`define LA_FIFO_WIDTH 8
`define LA_FIFO_DEPTH 32

`endif

/* File: link_adaptor_pkg.sv */
package link_adaptor_pkg;

   // host access kinds decoded at chip select fall
   typedef enum logic [2:0] {
      acc_invalid = 3'h0,
      acc_rd_data = 3'h1,
      acc_wr_data = 3'h2,
      acc_rd_rxstat = 3'h3,
      acc_wr_rxstat = 3'h4,
      acc_rd_txstat = 3'h5,
      acc_wr_txstat = 3'h6
   } access_e;

   // host cycle state
   typedef enum logic {
      st_idle = 1'b0,
      st_sel = 1'b1
   } bus_state_e;

endpackage

/* File: link_adaptor_host_status_irq.sv */
`timescale 1ns/100ps
`include "link_adaptor_map.svh"

// receive byte buffer between the link and the input data register
module link_adaptor_fifo #(
   parameter int WIDTH = `LA_FIFO_WIDTH,
   parameter int DEPTH = `LA_FIFO_DEPTH
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   wire push = i_in_valid & o_in_ready;
   wire pop = o_out_valid & i_out_ready;

   // occupancy after this edge
   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign o_out_data = mem[rd_ptr];

   // pointers and honest full and empty flags
   // both flags come from the next count, so they stay
   // registered outputs and still are never a cycle late
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         o_in_ready <= 1'b1;
         o_out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
         o_in_ready <= next_count != (AW+1)'(DEPTH);
         o_out_valid <= next_count != '0;
      end
   end

   // storage, no reset needed
   // an entry is only read after its push, so its
   // power-up contents show at the output only while o_out_valid is low
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

endmodule // link_adaptor_fifo

// How it works
// - arriving data packet sets receive full flag
// - receive flag cleared only by data read, reset
// - enable bits store writes and read back
// - rx interrupt equals enable and receive flag
// - tx interrupt equals enable and empty flag
// - enable clear drops interrupt, set restores it
// - data read clears flag, sends acknowledge
// - data read or reset drops rx interrupt
// - written byte goes out, empty flag cleared
// - output data read changes nothing
// - empty flag high when empty, set on reset
// - empty flag returns high on incoming acknowledge
// - data write or reset drops tx interrupt
// - select and direction latched at select fall
// - input register holds data, ignores writes
module link_adaptor_host_status_irq (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_chip_select_n,
   input wire logic i_read_not_write,
   input wire logic [1:0] i_register_select,
   input wire logic [7:0] i_host_data_bus,
   output logic [7:0] o_host_data_bus,
   output logic o_host_data_bus_oe,
   output logic o_rx_irq_out,
   output logic o_tx_irq_out,
   input wire logic i_link_rx_valid,
   input wire logic [7:0] i_link_rx_data,
   output logic o_link_rx_ready,
   input wire logic i_link_rx_ack,
   output logic o_link_tx_valid,
   output logic [7:0] o_link_tx_data,
   input wire logic i_link_tx_ready,
   output logic o_link_ack_valid,
   input wire logic i_link_ack_ready
);
   logic [11:0] pin_meta;
   logic [11:0] pin_sync;
   logic cs_n_prev;
   link_adaptor_pkg::bus_state_e state;
   link_adaptor_pkg::access_e acc;
   logic rx_full;
   logic rx_ie;
   logic tx_empty;
   logic tx_ie;
   logic [7:0] rx_data;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic next_rx_full;
   logic next_tx_empty;
   logic next_rx_ie;
   logic next_tx_ie;

   // host bus timing in clock edges, pin change at edge 0:
   // edge 1 first stage, edge 2 second stage, edge 3 action.
   // a select low or high must therefore be sampled by at least
   // one clock edge, or the edge is never seen.
   // reads act at select fall, so the read side effects
   // (flag clear, interrupt drop, acknowledge) are early.
   // writes take the data byte at select rise, when the
   // host guarantees that it is stable.
   // the bus enable is dropped at edge 3 of the rise, with the write.

   // status byte image: flag at bit 0, enable at bit 1
   function automatic logic [7:0] status_byte(input logic ie, input logic flag);
      status_byte = 8'h00;
      status_byte[`LA_IE_BIT] = ie;
      status_byte[`LA_FLAG_BIT] = flag;
   endfunction

   // pin synchronisers, first stage read only by the second
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pin_meta <= 12'hfff;
         pin_sync <= 12'hfff;
      end else begin
         pin_meta <= {i_chip_select_n, i_read_not_write, i_register_select, i_host_data_bus};
         pin_sync <= pin_meta;
      end
   end

   // synchronised pin fields and select edges
   wire cs_n_s = pin_sync[11];
   wire rnw_s = pin_sync[10];
   wire [1:0] rs_s = pin_sync[9:8];
   wire [7:0] bus_s = pin_sync[7:0];
   wire cs_fall = cs_n_prev & ~cs_n_s;
   wire cs_rise = ~cs_n_prev & cs_n_s & (state == link_adaptor_pkg::st_sel);

   // access decode of select lines and direction
   wire [2:0] sel_code = {rs_s, rnw_s};
   link_adaptor_pkg::access_e next_acc;
   always_comb begin
      unique case (sel_code)
         {`LA_SEL_DATA, 1'b1}: next_acc = link_adaptor_pkg::acc_rd_data;
         {`LA_SEL_TXDATA, 1'b0}: next_acc = link_adaptor_pkg::acc_wr_data;
         {`LA_SEL_RXSTAT, 1'b1}: next_acc = link_adaptor_pkg::acc_rd_rxstat;
         {`LA_SEL_RXSTAT, 1'b0}: next_acc = link_adaptor_pkg::acc_wr_rxstat;
         {`LA_SEL_TXSTAT, 1'b1}: next_acc = link_adaptor_pkg::acc_rd_txstat;
         {`LA_SEL_TXSTAT, 1'b0}: next_acc = link_adaptor_pkg::acc_wr_txstat;
         default: next_acc = link_adaptor_pkg::acc_invalid;
      endcase
   end

   // strobes: reads act at select fall, writes at select rise
   wire rd_data = cs_fall & (next_acc == link_adaptor_pkg::acc_rd_data);
   wire wr_data = cs_rise & (acc == link_adaptor_pkg::acc_wr_data);
   wire wr_rxstat = cs_rise & (acc == link_adaptor_pkg::acc_wr_rxstat);
   wire wr_txstat = cs_rise & (acc == link_adaptor_pkg::acc_wr_txstat);
   wire rx_load = ~rx_full & fifo_valid;

   // flag and enable next values, a set wins over a clear
   assign next_rx_full = rx_load | (rx_full & ~rd_data);
   assign next_tx_empty = i_link_rx_ack | (tx_empty & ~wr_data);
   assign next_rx_ie = wr_rxstat ? bus_s[`LA_IE_BIT] : rx_ie;
   assign next_tx_ie = wr_txstat ? bus_s[`LA_IE_BIT] : tx_ie;

   // status images, upper bits always zero
   wire [7:0] rx_stat = status_byte(rx_ie, rx_full);
   wire [7:0] tx_stat = status_byte(tx_ie, tx_empty);

   // read mux, selected by the access decoded this cycle
   // invalid and output data reads give zero
   logic [7:0] rd_value;
   always_comb begin
      unique case (next_acc)
         link_adaptor_pkg::acc_rd_data: rd_value = rx_data;
         link_adaptor_pkg::acc_rd_rxstat: rd_value = rx_stat;
         link_adaptor_pkg::acc_rd_txstat: rd_value = tx_stat;
         default: rd_value = `LA_BYTE_RST;
      endcase
   end


   // receive buffer; its ready is the link back-pressure
   // a byte leaves the buffer only while the input register
   // is free, so an unread byte is never overwritten
   link_adaptor_fifo #(
      .WIDTH(`LA_FIFO_WIDTH),
      .DEPTH(`LA_FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_in_valid(i_link_rx_valid),
      .o_in_ready(o_link_rx_ready),
      .i_in_data(i_link_rx_data),
      .o_out_valid(fifo_valid),
      .i_out_ready(~rx_full),
      .o_out_data(fifo_data)
   );


   // host cycle tracking and bus drive
   // the read value is frozen at select fall and held until
   // the rise, so a later flag change cannot tear the byte
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cs_n_prev <= 1'b1;
         state <= link_adaptor_pkg::st_idle;
         acc <= link_adaptor_pkg::acc_invalid;
         o_host_data_bus <= `LA_BYTE_RST;
         o_host_data_bus_oe <= 1'b0;
      end else begin
         cs_n_prev <= cs_n_s;
         if (cs_fall) begin
            state <= link_adaptor_pkg::st_sel;
            acc <= next_acc;
            o_host_data_bus <= rd_value;
            o_host_data_bus_oe <= rnw_s;
         end else if (cs_rise) begin
            state <= link_adaptor_pkg::st_idle;
            o_host_data_bus_oe <= 1'b0;
         end
      end
   end


   // flags, enables, input data register and interrupts
   // the interrupts use the next values, so an enable write
   // or a flag change shows on the pin at the same edge
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         rx_full <= `LA_RX_FULL_RST;
         tx_empty <= `LA_TX_EMPTY_RST;
         rx_ie <= `LA_IE_RST;
         tx_ie <= `LA_IE_RST;
         rx_data <= `LA_BYTE_RST;
         o_rx_irq_out <= 1'b0;
         o_tx_irq_out <= 1'b0;
      end else begin
         rx_full <= next_rx_full;
         tx_empty <= next_tx_empty;
         rx_ie <= next_rx_ie;
         tx_ie <= next_tx_ie;
         if (rx_load) begin
            rx_data <= fifo_data;
         end
         o_rx_irq_out <= next_rx_ie & next_rx_full;
         o_tx_irq_out <= next_tx_ie & next_tx_empty;
      end
   end


   // outgoing data packet and acknowledge requests
   // each request stands until the link takes it; a second
   // write before the link takes it overwrites the pending byte
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_link_tx_valid <= 1'b0;
         o_link_tx_data <= `LA_BYTE_RST;
         o_link_ack_valid <= 1'b0;
      end else begin
         if (wr_data) begin
            o_link_tx_valid <= 1'b1;
            o_link_tx_data <= bus_s;
         end else if (i_link_tx_ready) begin
            o_link_tx_valid <= 1'b0;
         end
         if (rd_data) begin
            o_link_ack_valid <= 1'b1;
         end else if (i_link_ack_ready) begin
            o_link_ack_valid <= 1'b0;
         end
      end
   end

endmodule // link_adaptor_host_status_irq

/* File: link_adaptor_host_status_irq_chk.sv */
`timescale 1ns/100ps
// port checks of the host status and interrupt block
module link_adaptor_host_status_irq_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_chip_select_n,
   input wire logic i_link_rx_ack,
   input wire logic i_link_tx_ready,
   input wire logic i_link_ack_ready,
   input logic o_host_data_bus_oe,
   input logic o_rx_irq_out,
   input logic o_tx_irq_out,
   input logic o_link_tx_valid,
   input logic [7:0] o_link_tx_data,
   input logic o_link_ack_valid
);
   logic [3:0] idle;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // cycles since the host last selected the device
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) idle <= 4'hf;
      else if (!i_chip_select_n) idle <= 4'h0;
      else if (idle != 4'hf) idle <= idle + 4'h1;
   end
   sequence s_desel;
      i_chip_select_n [*6];
   endsequence
   sequence s_ack_start;
      $rose(o_link_ack_valid);
   endsequence
   a_ack_held: assert property (
      o_link_ack_valid && !i_link_ack_ready |=> o_link_ack_valid) else $error("ack dropped early");
   a_tx_held: assert property (
      o_link_tx_valid && !i_link_tx_ready |=> o_link_tx_valid && $stable(o_link_tx_data)) else $error("tx moved");
   a_ack_on_read: assert property (
      s_ack_start |-> o_host_data_bus_oe && !o_rx_irq_out) else $error("ack without read");
   a_tx_irq_drop: assert property (
      $rose(o_link_tx_valid) |-> !o_tx_irq_out) else $error("tx irq kept on send");
   a_oe_idle: assert property (
      s_desel |-> !o_host_data_bus_oe) else $error("bus driven deselected");
   a_rx_irq_cause: assert property (
      $fell(o_rx_irq_out) |-> idle < 4'h8) else $error("rx irq fell alone");
   a_tx_irq_cause: assert property (
      $rose(o_tx_irq_out) |-> $past(i_link_rx_ack) || $past(i_link_rx_ack, 2) || idle < 4'h8) else $error("tx irq rose");
   a_tx_irq_keep: assert property (
      $fell(o_tx_irq_out) |-> idle < 4'h8) else $error("tx irq fell alone");
endmodule // link_adaptor_host_status_irq_chk

bind link_adaptor_host_status_irq link_adaptor_host_status_irq_chk u_chk (.i_clk_sys, .i_rst, .i_chip_select_n,
   .i_link_rx_ack, .i_link_tx_ready, .i_link_ack_ready, .o_host_data_bus_oe, .o_rx_irq_out, .o_tx_irq_out,
   .o_link_tx_valid, .o_link_tx_data, .o_link_ack_valid);

/* File: link_adaptor_link_model.sv */
`timescale 1ns/100ps
// link far side: offers bytes, takes packets, returns acknowledge
module link_adaptor_link_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_slow,
   input wire logic i_send,
   input wire logic [7:0] i_byte,
   output logic o_valid,
   output logic [7:0] o_data,
   input wire logic i_ready,
   output logic o_ack,
   input wire logic i_tx_valid,
   output logic o_rdy
);
   logic [1:0] ph;
   logic [3:0] cnt;
   // slow mode accepts one cycle in four
   assign o_rdy = !i_slow || ph == 2'h0;
   // offer held until taken, then the data lines show the inverse
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ph <= 2'h0;
         cnt <= 4'h0;
         o_valid <= 1'b0;
         o_data <= 8'h00;
         o_ack <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         o_ack <= cnt == 4'h1;
         if (cnt != 4'h0) cnt <= cnt - 4'h1;
         if (i_tx_valid && o_rdy) cnt <= 4'hf;
         if (i_send) o_valid <= 1'b1;
         if (i_send) o_data <= i_byte;
         else if (o_valid && i_ready) begin
            o_valid <= 1'b0;
            o_data <= ~o_data;
         end
      end
   end
endmodule // link_adaptor_link_model

/* File: tb_link_adaptor_host_status_irq.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
`define WAITC(c) begin for (int k = 0; k < 300 && !(c); k++) @(posedge clk); if (!(c)) begin n_fail++; summarize(); end end
// bench for the host status and interrupt block
module tb_link_adaptor_host_status_irq;
   logic clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rnw = 1'b1, slow = 1'b0, send = 1'b0;
   logic [1:0] rs = 2'h0;
   logic [7:0] drv = 8'h00, byte_in = 8'h00, q, dout, rd, td;
   logic oe, rx_irq, tx_irq, rv, rr, ack, tv, av, rdy;
   wire [7:0] bus = oe ? dout : drv;
   int n_fail = 0, compares = 0;
   // row: select, written status, read back, rx irq, tx irq
   logic [19:0] rows [6] = '{{2'h3, 8'h02, 8'h03, 2'h1}, {2'h3, 8'h00, 8'h01, 2'h0}, {2'h3, 8'h02, 8'h03, 2'h1},
      {2'h2, 8'h02, 8'h02, 2'h1}, {2'h2, 8'h00, 8'h00, 2'h1}, {2'h3, 8'h00, 8'h01, 2'h0}};
   link_adaptor_host_status_irq u_dut (.i_clk_sys(clk), .i_rst(rst), .i_chip_select_n(cs_n),
      .i_read_not_write(rnw), .i_register_select(rs), .i_host_data_bus(bus), .o_host_data_bus(dout),
      .o_host_data_bus_oe(oe), .o_rx_irq_out(rx_irq), .o_tx_irq_out(tx_irq), .i_link_rx_valid(rv),
      .i_link_rx_data(rd), .o_link_rx_ready(rr), .i_link_rx_ack(ack), .o_link_tx_valid(tv),
      .o_link_tx_data(td), .i_link_tx_ready(rdy), .o_link_ack_valid(av), .i_link_ack_ready(rdy));
   link_adaptor_link_model u_link (.i_clk_sys(clk), .i_rst(rst), .i_slow(slow), .i_send(send),
      .i_byte(byte_in), .o_valid(rv), .o_data(rd), .i_ready(rr), .o_ack(ack), .i_tx_valid(tv), .o_rdy(rdy));
   initial forever #2.5 clk = ~clk;
   // one host bus cycle; read value lands in q
   task automatic acc(input logic [1:0] s, input logic r, input logic [7:0] d);
      @(posedge clk);
      rs <= s;
      rnw <= r;
      drv <= d;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1 q = bus;
      @(posedge clk);
      cs_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   task automatic summarize;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      acc(2'h2, 1'b1, 8'h00);
      `CHK(q, 8'h00)
      `CHK(rr, 1'b1)
      acc(2'h3, 1'b1, 8'h00);
      `CHK(q, 8'h01)
      $display("reset test done");
      foreach (rows[i]) begin
         acc(rows[i][19:18], 1'b0, rows[i][17:10]);
         acc(rows[i][19:18], 1'b1, 8'h00);
         `CHK({q, rx_irq, tx_irq}, rows[i][9:0])
      end
      $display("status table done");
      acc(2'h2, 1'b0, 8'h02);
      acc(2'h0, 1'b0, 8'h77);
      `CHK(rx_irq, 1'b0)
      send <= 1'b1;
      byte_in <= 8'ha5;
      @(posedge clk);
      send <= 1'b0;
      `WAITC(rx_irq)
      acc(2'h2, 1'b0, 8'h00);
      `CHK(rx_irq, 1'b0)
      acc(2'h2, 1'b0, 8'h02);
      `CHK(rx_irq, 1'b1)
      acc(2'h0, 1'b1, 8'h00);
      `CHK({q, rx_irq}, {8'ha5, 1'b0})
      acc(2'h2, 1'b1, 8'h00);
      `CHK(q, 8'h02)
      $display("receive test done");
      slow <= 1'b1;
      acc(2'h3, 1'b0, 8'h02);
      acc(2'h1, 1'b0, 8'h3c);
      `CHK({tx_irq, td}, {1'b0, 8'h3c})
      acc(2'h3, 1'b1, 8'h00);
      `CHK(q, 8'h02)
      `WAITC(tx_irq)
      `CHK({tv, av}, 2'h0)
      acc(2'h1, 1'b1, 8'h00);
      `CHK({q, tx_irq}, {8'h00, 1'b1})
      $display("transmit test done");
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      `CHK({rx_irq, tx_irq}, 2'h0)
      acc(2'h3, 1'b1, 8'h00);
      `CHK(q, 8'h01)
      $display("second reset test done");
      summarize();
   end
endmodule // tb_link_adaptor_host_status_irq
